//--- sim/sil_contacts.sv
// Switch contact model driving the four discrete inputs
`timescale 1ns/1ps
`default_nettype none

module sil_contacts (
	// Clock
	input  wire logic       core_clk_in,
	// Requested closures {rev, fwd, clear, enable}
	input  wire logic [3:0] close_in,
	// Contact levels, high when shorted to the common
	output logic            drive_enable_input_out,
	output logic            fault_clear_input_out,
	output logic            forward_limit_input_out,
	output logic            reverse_limit_input_out
);
	logic [3:0] pins = 4'h0;

	// Contacts move just after an edge; all contacts open before the first edge
	always_ff @(posedge core_clk_in) begin
		pins <= close_in;
	end
	assign {reverse_limit_input_out, forward_limit_input_out} = pins[3:2];
	assign {fault_clear_input_out, drive_enable_input_out} = pins[1:0];
endmodule // sil_contacts
`default_nettype wire

//--- sim/sil_interlock_asserts.sv
// Port assertions for the servo input interlock
`timescale 1ns/1ps
`default_nettype none

module sil_interlock_asserts (
	// Clock and reset
	input wire logic       core_clk_in,
	input wire logic       rst_in,
	// Watched pins and bus
	input wire logic       drive_enable_input_in,
	input wire logic       forward_limit_input_in,
	input wire logic       psel_in,
	input wire logic       penable_in,
	input wire logic [7:0] paddr_in,
	// Watched outputs
	input wire logic       pslverr_out,
	input wire logic       base_drive_out,
	input wire logic       servo_lock_out,
	input wire logic [7:0] torque_scale_out,
	input wire logic       ccw_allow_out,
	input wire logic       cw_allow_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (rst_in);

	// ---------------------------------------------------------------
	// Drive, lock and direction gating
	// ---------------------------------------------------------------
	a_lock_has_drive: assert property (servo_lock_out |-> base_drive_out)
		else $error("lock without drive");
	a_lock_no_torque: assert property (servo_lock_out [*2] |-> torque_scale_out == 8'h00)
		else $error("torque while locked");
	a_ccw_needs_drive: assert property (ccw_allow_out |-> base_drive_out)
		else $error("ccw allowed while off");
	a_cw_needs_drive: assert property (cw_allow_out |-> base_drive_out)
		else $error("cw allowed while off");
	a_coast_no_torque: assert property (!base_drive_out [*2] |-> torque_scale_out == 8'h00)
		else $error("torque while coasting");

	// ---------------------------------------------------------------
	// Input filtering and bus errors
	// ---------------------------------------------------------------
	a_enable_filtered: assert property ($changed(drive_enable_input_in) && !psel_in |=> $stable(base_drive_out))
		else $error("enable glitch passed");
	a_limit_filtered: assert property ($changed(forward_limit_input_in) && !psel_in |=> $stable(ccw_allow_out))
		else $error("limit glitch passed");
	a_unmapped_err: assert property (psel_in && penable_in && paddr_in > 8'h10 |-> pslverr_out)
		else $error("no error on unmapped");
endmodule // sil_interlock_asserts

bind sil_interlock sil_interlock_asserts sil_interlock_asserts_i (
	.core_clk_in(core_clk_in), .rst_in(rst_in),
	.drive_enable_input_in(drive_enable_input_in),
	.forward_limit_input_in(forward_limit_input_in),
	.psel_in(psel_in), .penable_in(penable_in), .paddr_in(paddr_in),
	.pslverr_out(pslverr_out), .base_drive_out(base_drive_out),
	.servo_lock_out(servo_lock_out), .torque_scale_out(torque_scale_out),
	.ccw_allow_out(ccw_allow_out), .cw_allow_out(cw_allow_out));
`default_nettype wire

//--- sim/sil_interlock_tb_top.sv
// Self-checking bench for the servo input interlock
`timescale 1ns/1ps
`default_nettype none

module sil_interlock_tb_top
	import sil_pkg::*;
;
	logic        clk = 1'h0;
	logic        rst = 1'h1;
	logic [3:0]  close = 4'h0;
	logic        psel = 1'h0;
	logic        penable = 1'h0;
	logic        pwrite = 1'h0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic [31:0] prdata_out;
	logic        err, pready_out, pslverr_out, base_drive_out;
	logic        servo_lock_out, ccw_allow_out, cw_allow_out;
	logic        en_pin, clr_pin, fwd_pin, rev_pin;
	logic [7:0]  torque_scale_out;
	int          failures = 0;
	int          checks_done = 0;

	// Clock
	always #20 clk = ~clk;

	sil_contacts sil_contacts_i (.core_clk_in(clk), .close_in(close),
		.drive_enable_input_out(en_pin), .fault_clear_input_out(clr_pin),
		.forward_limit_input_out(fwd_pin), .reverse_limit_input_out(rev_pin));
	sil_interlock sil_interlock_i (.core_clk_in(clk), .rst_in(rst),
		.drive_enable_input_in(en_pin), .fault_clear_input_in(clr_pin),
		.forward_limit_input_in(fwd_pin), .reverse_limit_input_in(rev_pin),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.base_drive_out(base_drive_out), .servo_lock_out(servo_lock_out),
		.torque_scale_out(torque_scale_out), .ccw_allow_out(ccw_allow_out),
		.cw_allow_out(cw_allow_out));

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic end_of_test();
		if (failures == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready_out !== 1'h1 && n < 50);
		if (pready_out !== 1'h1) begin
			failures++;
			end_of_test();
		end
		rd = prdata_out;
		err = pslverr_out;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic settle();
		repeat (3) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic poll(input logic [3:0] e);
		int n;
		n = 0;
		do begin
			apb(1'h0, ADDR_STATUS, 32'h0);
			n++;
		end while (rd[3:0] !== e && n < 20000);
		chk(rd[3:0], e);
		if (rd[3:0] !== e)
			end_of_test();
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		for (int i = 0; i < 4; i++) begin
			apb(1'h0, 8'(i * 4), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'h1, ADDR_STOP, 32'hFFFFFFFF);
		apb(1'h0, ADDR_STOP, 32'h0);
		chk(rd, 32'h1);
		apb(1'h1, ADDR_STOP, 32'h0);
		apb(1'h0, 8'h20, 32'h0);
		chk(err, 32'h1);
		chk(base_drive_out, 32'h0);
	endtask

	task automatic t_force();
		for (int i = 1; i < 8; i += 2) begin
			apb(1'h1, ADDR_AUTO, 32'(i));
			settle();
			chk(base_drive_out, 32'h1);
			chk({ccw_allow_out, cw_allow_out}, {i[1], i[2]});
		end
		chk(torque_scale_out, RAMP_FULL);
	endtask

	task automatic t_stop(input logic slow);
		apb(1'h1, ADDR_STOP, {31'h0, slow});
		apb(1'h1, ADDR_CTRL, 32'h2);
		apb(1'h1, ADDR_AUTO, 32'h5);
		settle();
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk(rd[5:4], slow ? 32'h2 : 32'h3);
		chk(servo_lock_out, !slow);
		repeat (DECEL_CYCLES + 100) @(posedge clk);
		@(negedge clk);
		chk(torque_scale_out inside {[8'hFC:8'hFE]}, slow);
		apb(1'h1, ADDR_AUTO, 32'h7);
		settle();
		chk(servo_lock_out, 32'h0);
	endtask

	task automatic t_pins();
		apb(1'h1, ADDR_CTRL, 32'h0);
		apb(1'h1, ADDR_AUTO, 32'h0);
		settle();
		chk(base_drive_out, 32'h0);
		@(posedge clk);
		close <= 4'hD;
		repeat (100) @(posedge clk);
		close <= 4'h0;
		repeat (200) @(posedge clk);
		apb(1'h0, ADDR_STATUS, 32'h0);
		chk(rd[3:0], 32'h0);
		close <= 4'hF;
		poll(4'hF);
		settle();
		chk(base_drive_out, 32'h0);
		apb(1'h1, ADDR_RESET, 32'h1);
		settle();
		chk(base_drive_out, 32'h1);
		chk({ccw_allow_out, cw_allow_out}, 32'h3);
		apb(1'h1, ADDR_RESET, 32'h0);
		apb(1'h1, ADDR_CTRL, 32'h1);
		settle();
		chk(base_drive_out, 32'h1);
		@(posedge clk);
		close <= 4'hC;
		poll(4'hC);
		apb(1'h1, ADDR_CTRL, 32'h0);
		settle();
		chk(base_drive_out, 32'h0);
		chk(torque_scale_out, 32'h0);
	endtask

	// Main sequence
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		t_regs();
		t_force();
		t_stop(1'h0);
		t_stop(1'h1);
		t_pins();
		end_of_test();
	end
endmodule // sil_interlock_tb_top
`default_nettype wire

//--- verilog/sil_filter.sv
// Synchroniser and debounce filter for one discrete input
`timescale 1ns/1ps
`default_nettype none

module sil_filter
	import sil_pkg::*;
(
	// Clock and reset
	input  wire logic core_clk_in,
	input  wire logic rst_in,
	// Raw pin and clean level
	input  wire logic raw_in,
	output logic      level_out
);

	logic                sync_a;
	logic                sync_b;
	logic [FILTER_W-1:0] count;
	logic                level;
	logic [FILTER_W-1:0] next_count;
	logic                next_level;

	// Accept a new level only after it has held for the filter time
	always_comb begin
		next_count = '0;
		next_level = level;
		if (sync_b != level) begin
			if (count == FILTER_W'(FILTER_CYCLES - 1)) begin
				next_level = sync_b;
			end else begin
				next_count = count + FILTER_W'(1);
			end
		end
	end

	// Two-stage sync then filter state
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			sync_a <= 1'b0;
			sync_b <= 1'b0;
			count  <= '0;
			level  <= 1'b0;
		end else begin
			sync_a <= raw_in;
			sync_b <= sync_a;
			count  <= next_count;
			level  <= next_level;
		end
	end

	assign level_out = level;

endmodule // sil_filter

`default_nettype wire

//--- verilog/sil_interlock.sv
// Servo input interlock: drive enable, fault clear and stroke limits
//
// What this block does
// - Any input change takes effect in under 10 ms, except a limit closing in a slow stop, which waits until the ramp locks.
// - Drive enable input asserted turns base drive on, servo on.
// - Drive enable input released turns base drive off, motor coasts.
// - Automation bit forces drive enable input asserted.
// - Fault clear without alarm cuts base drive while held.
// - Reset-behaviour bit keeps base drive on during fault clear.
// - Opening limit gives sudden stop, then servo lock.
// - Stop-mode bit selects slow decelerating stop instead.
// - Limit reads 0 when open, 1 when shorted.
// - Automation bits force either limit asserted.
`timescale 1ns/1ps
`default_nettype none

module sil_interlock
	import sil_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk_in,
	input  wire logic        rst_in,
	// Discrete inputs, high when shorted to the supply common
	input  wire logic        drive_enable_input_in,
	input  wire logic        fault_clear_input_in,
	input  wire logic        forward_limit_input_in,
	input  wire logic        reverse_limit_input_in,
	// APB slave
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	output logic [31:0]      prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	// Power stage and motion
	output logic             base_drive_out,
	output logic             servo_lock_out,
	output logic [7:0]       torque_scale_out,
	output logic             ccw_allow_out,
	output logic             cw_allow_out
);

	// ---------------------------------------------------------------
	// Input conditioning
	// ---------------------------------------------------------------
	logic [3:0] raw;
	logic [3:0] clean;

	assign raw = {reverse_limit_input_in, forward_limit_input_in,
		fault_clear_input_in, drive_enable_input_in};

	// Filter each pin; 2 ms settle keeps reaction under 10 ms
	for (genvar i = 0; i < 4; i++) begin : g_filt
		sil_filter u_filt (
			.core_clk_in (core_clk_in),
			.rst_in      (rst_in),
			.raw_in      (raw[i]),
			.level_out   (clean[i])
		);
	end

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [2:0] auto_on;
	logic       reset_keep;
	logic       stop_slow;
	logic [2:0] ctrl;
	logic [2:0] next_auto_on;
	logic       next_reset_keep;
	logic       next_stop_slow;
	logic [2:0] next_ctrl;
	logic [31:0] next_prdata;
	logic [31:0] prdata;
	logic        access;
	logic        hit;

	assign access = psel_in && penable_in;

	// Address decode for the slave error response only
	function automatic logic addr_hit(input logic [7:0] a);
		return a == ADDR_AUTO || a == ADDR_RESET || a == ADDR_STOP ||
			a == ADDR_CTRL || a == ADDR_STATUS;
	endfunction

	assign hit = addr_hit(paddr_in);

	// ---------------------------------------------------------------
	// Effective input levels
	// ---------------------------------------------------------------
	logic enable_eff;
	logic fwd_eff;
	logic rev_eff;
	logic alarm;
	logic clear_cut;

	assign alarm      = ctrl[CTRL_ALARM_BIT];
	assign enable_eff = clean[0] | auto_on[AUTO_ENABLE_BIT];
	// Open pin reads 0, shorted pin reads 1
	assign fwd_eff    = clean[2] | auto_on[AUTO_FWD_BIT];
	assign rev_eff    = clean[3] | auto_on[AUTO_REV_BIT];
	// Fault clear with no alarm cuts drive unless kept
	assign clear_cut  = clean[1] && !alarm && !reset_keep;

	// ---------------------------------------------------------------
	// Stop sequencer
	// ---------------------------------------------------------------
	sil_state_t          state;
	sil_state_t          next_state;
	logic [RAMP_W-1:0]   ramp;
	logic [RAMP_W-1:0]   next_ramp;
	logic [FILTER_W-1:0] tick;
	logic [FILTER_W-1:0] next_tick;
	logic                limit_hit;
	logic                ccw_cmd;
	logic                cw_cmd;

	assign ccw_cmd   = ctrl[CTRL_CCW_BIT];
	assign cw_cmd    = ctrl[CTRL_CW_BIT];
	// Commanded direction blocked by an open limit
	assign limit_hit = (ccw_cmd && !fwd_eff) || (cw_cmd && !rev_eff);

	// Next state, ramp and step timer
	always_comb begin
		next_state = state;
		next_ramp  = ramp;
		next_tick  = '0;
		unique case (state)
			SIL_OFF: begin
				next_ramp = '0;
				if (enable_eff && !clear_cut) begin
					next_state = SIL_RUN;
					next_ramp  = RAMP_FULL;
				end
			end
			SIL_RUN: begin
				if (limit_hit) begin
					if (stop_slow) begin
						next_state = SIL_STOPPING;
					end else begin
						next_state = SIL_LOCKED;
						next_ramp  = '0;
					end
				end
			end
			SIL_STOPPING: begin
				next_tick = tick + FILTER_W'(1);
				if (tick == FILTER_W'(DECEL_CYCLES - 1)) begin
					next_tick = '0;
					if (ramp == '0) begin
						next_state = SIL_LOCKED;
					end else begin
						next_ramp = ramp - RAMP_W'(1);
					end
				end
			end
			SIL_LOCKED: begin
				next_ramp = '0;
				if (!limit_hit) begin
					next_state = SIL_RUN;
					next_ramp  = RAMP_FULL;
				end
			end
		endcase
		// Loss of enable or clear_cut (fault clear, no alarm, not kept) always coasts the motor
		if (!enable_eff || clear_cut) begin
			next_state = SIL_OFF;
			next_ramp  = '0;
			next_tick  = '0;
		end
	end

	// ---------------------------------------------------------------
	// APB next values
	// ---------------------------------------------------------------
	always_comb begin
		next_auto_on    = auto_on;
		next_reset_keep = reset_keep;
		next_stop_slow  = stop_slow;
		next_ctrl       = ctrl;
		next_prdata     = prdata;
		if (access && pwrite_in) begin
			unique case (paddr_in)
				ADDR_AUTO:  next_auto_on    = pwdata_in[2:0];
				ADDR_RESET: next_reset_keep = pwdata_in[RESET_KEEP_BIT];
				ADDR_STOP:  next_stop_slow  = pwdata_in[STOP_SLOW_BIT];
				ADDR_CTRL:  next_ctrl       = pwdata_in[2:0];
				default:    next_ctrl       = ctrl;
			endcase
		end
		if (psel_in && !penable_in && !pwrite_in) begin
			unique case (paddr_in)
				ADDR_AUTO:   next_prdata = {29'h0, auto_on};
				ADDR_RESET:  next_prdata = {31'h0, reset_keep};
				ADDR_STOP:   next_prdata = {31'h0, stop_slow};
				ADDR_CTRL:   next_prdata = {29'h0, ctrl};
				ADDR_STATUS: next_prdata = {18'h0, ramp, state, clean};
				default:     next_prdata = 32'h0;
			endcase
		end
	end

	// All registered state
	always_ff @(posedge core_clk_in) begin
		if (rst_in) begin
			auto_on    <= AUTO_RST;
			reset_keep <= RESET_RST;
			stop_slow  <= STOP_RST;
			ctrl       <= CTRL_RST;
			prdata     <= 32'h0;
			state      <= SIL_OFF;
			ramp       <= '0;
			tick       <= '0;
		end else begin
			auto_on    <= next_auto_on;
			reset_keep <= next_reset_keep;
			stop_slow  <= next_stop_slow;
			ctrl       <= next_ctrl;
			prdata     <= next_prdata;
			state      <= next_state;
			ramp       <= next_ramp;
			tick       <= next_tick;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign prdata_out       = prdata;
	assign pready_out       = 1'b1;                  // Zero wait states
	assign pslverr_out      = access && !hit;
	assign base_drive_out   = (state != SIL_OFF);
	assign servo_lock_out   = (state == SIL_LOCKED);
	assign torque_scale_out = ramp;
	// Direction permits from limit levels
	assign ccw_allow_out    = base_drive_out && fwd_eff;
	assign cw_allow_out     = base_drive_out && rev_eff;

endmodule // sil_interlock

`default_nettype wire

//--- verilog/sil_pkg.sv
// Package of constants and types for the servo input interlock block
package sil_pkg;

	// ---------------------------------------------------------------
	// Clock and filter timing
	// ---------------------------------------------------------------
	localparam int CLK_FREQ_HZ      = 25_000_000;
	localparam int ACCEPT_MAX_MS    = 10;   // Longest acceptance delay
	localparam int FILTER_TIME_US   = 2000; // Debounce settle time
	localparam int FILTER_CYCLES    =
		(CLK_FREQ_HZ / 1_000_000) * FILTER_TIME_US;
	localparam int FILTER_W         = 16;
	localparam int DECEL_TIME_US    = 100;  // Slow-stop ramp per step
	localparam int DECEL_CYCLES     =
		(CLK_FREQ_HZ / 1_000_000) * DECEL_TIME_US;
	localparam int RAMP_W           = 8;
	localparam logic [RAMP_W-1:0] RAMP_FULL = 8'hFF;

	// ---------------------------------------------------------------
	// APB register map (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_AUTO   = 8'h00; // Input automation
	localparam logic [7:0] ADDR_RESET  = 8'h04; // Reset behaviour
	localparam logic [7:0] ADDR_STOP   = 8'h08; // Stop mode
	localparam logic [7:0] ADDR_CTRL   = 8'h0C; // Alarm, direction cmd
	localparam logic [7:0] ADDR_STATUS = 8'h10; // Live state

	// Field positions
	localparam int AUTO_ENABLE_BIT  = 0;
	localparam int AUTO_FWD_BIT     = 1;
	localparam int AUTO_REV_BIT     = 2;
	localparam int RESET_KEEP_BIT   = 0;
	localparam int STOP_SLOW_BIT    = 0;
	localparam int CTRL_ALARM_BIT   = 0;
	localparam int CTRL_CCW_BIT     = 1;
	localparam int CTRL_CW_BIT      = 2;

	// Reset values
	localparam logic [2:0] AUTO_RST  = 3'h0;
	localparam logic       RESET_RST = 1'h0;
	localparam logic       STOP_RST  = 1'h0;
	localparam logic [2:0] CTRL_RST  = 3'h0;

	// Stop sequencer states
	typedef enum logic [1:0] {
		SIL_OFF,
		SIL_RUN,
		SIL_STOPPING,
		SIL_LOCKED
	} sil_state_t;

endpackage
